// ===== rtl/reg_bank.sv
/*
 small peripheral register bank showing r/w, r, w, reserved and alias behaviour.
 assumes a synchronous register port on mclk with one-cycle read latency.
*/
`timescale 1ns/10ps
module reg_bank
   import reg_conv_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      soft_reset,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   input  wire logic [ADDR_W-1:0]         addr,
   input  wire logic [DATA_W-1:0]         wdata,
   input  wire logic [5:0]                hw_status,
   output logic      [DATA_W-1:0]         rdata,
   output logic                           rvalid,
   output logic      [3:0]                ctrl_out,
   output logic      [DATA_W-1:0]         port_out,
   output logic                           cmd_pulse,
   output logic      [DATA_W-1:0]         cmd_data,
   output logic                           debug_out
);
   import reg_conv_pkg::*;

   alias_if #(.W(DATA_W)) out_bus ();

   logic [DATA_W-1:0] ctrl;
   logic [DATA_W-1:0] next_ctrl;
   logic [DATA_W-1:0] debug;
   logic [DATA_W-1:0] next_debug;
   logic [DATA_W-1:0] next_rdata;
   logic              next_rvalid;
   logic              next_cmd_pulse;
   logic [DATA_W-1:0] next_cmd_data;
   logic [DATA_W-1:0] read_mux;

   alias_register #(
      .W     (DATA_W),
      .RST   (OUT_RST)
   ) u_out (
      .mclk       (mclk),
      .reset      (reset),
      .soft_reset (soft_reset),
      .port       (out_bus)
   );

   // alias decode: one access reaches the base register
   always_comb begin
      out_bus.wr    = 1'b0;
      out_bus.op    = OP_WRITE;
      out_bus.wdata = wdata;
      if (wr_en) begin
         case (addr)
            ADDR_OUT: begin
               out_bus.wr = 1'b1;
               out_bus.op = OP_WRITE; // RULE_01
            end
            ADDR_OUTCLR: begin
               out_bus.wr = 1'b1;
               out_bus.op = OP_CLEAR; // RULE_11
            end
            ADDR_OUTSET: begin
               out_bus.wr = 1'b1;
               out_bus.op = OP_SET; // RULE_11
            end
            ADDR_OUTTGL: begin
               out_bus.wr = 1'b1;
               out_bus.op = OP_TOGGLE; // RULE_11
            end
            default: out_bus.wr = 1'b0;
         endcase
      end
   end

   // ctrl, debug and write-only command registers
   always_comb begin
      next_ctrl      = ctrl;
      next_debug     = debug;
      next_cmd_pulse = 1'b0;
      next_cmd_data  = cmd_data;
      if (soft_reset) begin
         next_ctrl     = CTRL_RST; // RULE_06
         next_cmd_data = CMD_RST;
      end else if (wr_en) begin
         case (addr)
            ADDR_CTRL: next_ctrl = wdata & CTRL_MASK; // RULE_01 RULE_04
            ADDR_CMD: begin
               next_cmd_pulse = 1'b1; // RULE_03
               next_cmd_data  = wdata;
            end
            default: next_ctrl = ctrl; // status writes dropped RULE_02
         endcase
      end
      // debug control survives peripheral software reset
      if (wr_en && addr == ADDR_DEBUG) begin
         next_debug = wdata & DEBUG_MASK; // RULE_06
      end
   end

   always_comb begin
      case (addr)
         ADDR_CTRL:   read_mux = ctrl & CTRL_MASK; // RULE_04
         ADDR_OUT:    read_mux = out_bus.value; // RULE_07
         ADDR_OUTCLR: read_mux = out_bus.value; // RULE_07
         ADDR_OUTSET: read_mux = out_bus.value; // RULE_07
         ADDR_OUTTGL: read_mux = out_bus.value; // RULE_07
         ADDR_STATUS: read_mux = {2'b00, hw_status} & STATUS_MASK; // RULE_02 RULE_04
         ADDR_CMD:    read_mux = '0; // RULE_03
         ADDR_DEBUG:  read_mux = debug & DEBUG_MASK;
         default:     read_mux = '0;
      endcase
      next_rdata  = rd_en ? read_mux : rdata;
      next_rvalid = rd_en;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl      <= CTRL_RST;
         debug     <= DEBUG_RST;
         rdata     <= '0;
         rvalid    <= 1'b0;
         cmd_pulse <= 1'b0;
         cmd_data  <= CMD_RST;
         ctrl_out  <= CTRL_RST[3:0];
         port_out  <= OUT_RST;
         debug_out <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         debug     <= next_debug;
         rdata     <= next_rdata;
         rvalid    <= next_rvalid;
         cmd_pulse <= next_cmd_pulse;
         cmd_data  <= next_cmd_data;
         ctrl_out  <= next_ctrl[3:0];
         port_out  <= out_bus.value;
         debug_out <= next_debug[0];
      end
   end

   sequence s_read_alias;
      rd_en && (addr == ADDR_OUTSET || addr == ADDR_OUTCLR || addr == ADDR_OUTTGL)
         && !out_bus.wr;
   endsequence

   property p_alias_read;
      @(posedge mclk) disable iff (reset)
         s_read_alias |=> rdata == port_out;
   endproperty
   a_alias_read: assert property (p_alias_read) else $error("alias read differs from base"); // RULE_07

   property p_reserved_zero;
      @(posedge mclk) disable iff (reset)
         rd_en && addr == ADDR_CTRL |=> rdata[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // RULE_04

   sequence s_ctrl_write;
      wr_en && addr == ADDR_CTRL && !soft_reset;
   endsequence

   sequence s_ctrl_read;
      rd_en && addr == ADDR_CTRL && !wr_en;
   endsequence

   property p_ctrl_rw;
      @(posedge mclk) disable iff (reset)
         s_ctrl_write ##1 s_ctrl_read
            |=> rdata == ($past(wdata, 2) & CTRL_MASK);
   endproperty
   a_ctrl_rw: assert property (p_ctrl_rw) else $error("ctrl readback wrong"); // RULE_01

   property p_status_ro;
      @(posedge mclk) disable iff (reset)
         rd_en && addr == ADDR_STATUS |=> rdata == {2'b00, $past(hw_status)};
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status read wrong"); // RULE_02

   property p_soft_reset;
      @(posedge mclk) disable iff (reset)
         soft_reset && !(wr_en && addr == ADDR_DEBUG)
            |=> ctrl == CTRL_RST && out_bus.value == OUT_RST && $stable(debug);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong"); // RULE_06

   // read port timing and write landing per register kind
   sequence s_out_write;
      wr_en && addr == ADDR_OUT && !soft_reset;
   endsequence

   sequence s_cmd_write;
      wr_en && addr == ADDR_CMD && !soft_reset;
   endsequence

   sequence s_debug_write;
      wr_en && addr == ADDR_DEBUG;
   endsequence

   property p_rvalid_pulse;
      @(posedge mclk) disable iff (reset)
         rd_en |=> rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("rvalid missing"); // RULE_01

   property p_rvalid_idle;
      @(posedge mclk) disable iff (reset)
         !rd_en |=> !rvalid;
   endproperty
   a_rvalid_idle: assert property (p_rvalid_idle) else $error("rvalid without read"); // RULE_01

   property p_rdata_hold;
      @(posedge mclk) disable iff (reset)
         !rd_en |=> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without read"); // RULE_01

   property p_out_rw;
      @(posedge mclk) disable iff (reset)
         s_out_write |=> out_bus.value == $past(wdata);
   endproperty
   a_out_rw: assert property (p_out_rw) else $error("out write lost"); // RULE_01

   property p_out_read;
      @(posedge mclk) disable iff (reset)
         rd_en && addr == ADDR_OUT |=> rdata == $past(out_bus.value);
   endproperty
   a_out_read: assert property (p_out_read) else $error("out read wrong"); // RULE_07

   property p_ctrl_out;
      @(posedge mclk) disable iff (reset)
         s_ctrl_write |=> ctrl_out == $past(wdata[3:0]);
   endproperty
   a_ctrl_out: assert property (p_ctrl_out) else $error("ctrl_out wrong"); // RULE_01

   property p_ctrl_hold;
      @(posedge mclk) disable iff (reset)
         !(wr_en && addr == ADDR_CTRL) && !soft_reset |=> $stable(ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl changed without write"); // RULE_01

   property p_ctrl_reserved_store;
      @(posedge mclk) disable iff (reset)
         s_ctrl_write |=> ctrl[7:4] == 4'h0;
   endproperty
   a_ctrl_reserved_store: assert property (p_ctrl_reserved_store) else $error("ctrl kept reserved"); // RULE_04

   property p_status_drop;
      @(posedge mclk) disable iff (reset)
         wr_en && addr == ADDR_STATUS && !soft_reset
            |=> $stable(ctrl) && $stable(debug) && $stable(cmd_data) && $stable(out_bus.value);
   endproperty
   a_status_drop: assert property (p_status_drop) else $error("status write had effect"); // RULE_02

   property p_cmd_store;
      @(posedge mclk) disable iff (reset)
         s_cmd_write |=> cmd_pulse && cmd_data == $past(wdata);
   endproperty
   a_cmd_store: assert property (p_cmd_store) else $error("cmd write lost"); // RULE_03

   property p_cmd_quiet;
      @(posedge mclk) disable iff (reset)
         !(wr_en && addr == ADDR_CMD && !soft_reset) |=> !cmd_pulse;
   endproperty
   a_cmd_quiet: assert property (p_cmd_quiet) else $error("cmd pulse without write"); // RULE_03

   property p_status_reserved;
      @(posedge mclk) disable iff (reset)
         rd_en && addr == ADDR_STATUS |=> rdata[7:6] == 2'b00;
   endproperty
   a_status_reserved: assert property (p_status_reserved) else $error("status reserved set"); // RULE_04

   property p_debug_reserved;
      @(posedge mclk) disable iff (reset)
         rd_en && addr == ADDR_DEBUG |=> rdata[7:1] == 7'h00;
   endproperty
   a_debug_reserved: assert property (p_debug_reserved) else $error("debug reserved set"); // RULE_04

   property p_unmapped_zero;
      @(posedge mclk) disable iff (reset)
         rd_en && addr > ADDR_DEBUG |=> rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // RULE_04

   property p_debug_write;
      @(posedge mclk) disable iff (reset)
         s_debug_write |=> debug == ($past(wdata) & DEBUG_MASK) && debug_out == $past(wdata[0]);
   endproperty
   a_debug_write: assert property (p_debug_write) else $error("debug write lost"); // RULE_06

   property p_debug_hold;
      @(posedge mclk) disable iff (reset)
         !(wr_en && addr == ADDR_DEBUG) |=> $stable(debug);
   endproperty
   a_debug_hold: assert property (p_debug_hold) else $error("debug changed without write"); // RULE_06

   property p_soft_cmd;
      @(posedge mclk) disable iff (reset)
         soft_reset |=> cmd_data == CMD_RST && !cmd_pulse;
   endproperty
   a_soft_cmd: assert property (p_soft_cmd) else $error("soft reset missed cmd"); // RULE_06
endmodule

// ===== rtl/reg_conv_pkg.sv
/*
 constants and types for the register bank with set, clear and toggle aliases.
 assumes a single clock domain and a simple synchronous register port.
*/
// How it works
// [RULE_01] read/write bits take written values and read them back.
// [RULE_02] read-only bits return hardware value; writes are discarded.
// [RULE_03] write-only bits accept writes; their read data is not defined.
// [RULE_04] reserved bit positions always read as zero.
// [RULE_05] software writes zero into every reserved bit position.
// [RULE_06] power-on and peripheral software reset load reset values, except debug control; power-on reset here also loads DEBUG_RST into debug.
// [RULE_07] base register and its alias read back identical contents.
// [RULE_08] a one written to the clear alias clears that base bit.
// [RULE_09] a one written to the set alias sets that base bit.
// [RULE_10] a one written to the toggle alias inverts that base bit.
// [RULE_11] alias writes change the base register in one access.
// [RULE_12] zero bits in an alias write leave base bits unchanged.
package reg_conv_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 4;
   // register indices
   localparam logic [3:0]  ADDR_CTRL    = 4'h0;
   localparam logic [3:0]  ADDR_OUT     = 4'h1;
   localparam logic [3:0]  ADDR_OUTCLR  = 4'h2;
   localparam logic [3:0]  ADDR_OUTSET  = 4'h3;
   localparam logic [3:0]  ADDR_OUTTGL  = 4'h4;
   localparam logic [3:0]  ADDR_STATUS  = 4'h5;
   localparam logic [3:0]  ADDR_CMD     = 4'h6;
   localparam logic [3:0]  ADDR_DEBUG   = 4'h7;
   // field masks: ctrl bits 3:0 r/w, upper reserved
   localparam logic [7:0]  CTRL_MASK    = 8'h0F;
   localparam logic [7:0]  STATUS_MASK  = 8'h3F;
   localparam logic [7:0]  DEBUG_MASK   = 8'h01;
   // reset values
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [7:0]  OUT_RST      = 8'h00;
   localparam logic [7:0]  CMD_RST      = 8'h00;
   localparam logic [7:0]  DEBUG_RST    = 8'h00;
   typedef enum logic [1:0] {OP_WRITE, OP_CLEAR, OP_SET, OP_TOGGLE} alias_op_t;
endpackage

// ===== rtl/alias_if.sv
/*
 carrier between the bank and its alias register: one write request and held value.
 assumes both ends share mclk.
*/
`timescale 1ns/10ps
interface alias_if #(parameter int W = 8);
   logic                 wr;
   reg_conv_pkg::alias_op_t op;
   logic [W-1:0]         wdata;
   logic [W-1:0]         value;
   modport bank  (output wr, output op, output wdata, input value);
   modport store (input wr, input op, input wdata, output value);
endinterface

// ===== rtl/alias_register.sv
/*
 base register with clear, set and toggle alias updates.
 assumes the bank decodes the alias address into an operation.
*/
`timescale 1ns/10ps
module alias_register
   import reg_conv_pkg::*;
#(
   parameter int          W     = 8,
   parameter logic [W-1:0] RST  = '0
)(
   input  wire logic      mclk,
   input  wire logic      reset,
   input  wire logic      soft_reset,
   alias_if.store         port
);
   logic [W-1:0] value;
   logic [W-1:0] next_value;

   always_comb begin
      next_value = value;
      if (soft_reset) begin
         next_value = RST; // RULE_06
      end else if (port.wr) begin
         case (port.op)
            OP_WRITE:  next_value = port.wdata;
            OP_CLEAR:  next_value = value & ~port.wdata; // RULE_08 RULE_12
            OP_SET:    next_value = value | port.wdata; // RULE_09 RULE_12
            OP_TOGGLE: next_value = value ^ port.wdata; // RULE_10 RULE_12
            default:   next_value = value;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         value <= RST;
      end else begin
         value <= next_value;
      end
   end

   assign port.value = value;

   property p_alias_single;
      @(posedge mclk) disable iff (reset)
         (port.wr && !soft_reset) |=> (value == $past(next_value)) && $changed(value)
            || $past(value) == $past(next_value);
   endproperty
   a_alias_single: assert property (p_alias_single) else $error("alias write not in one access"); // RULE_11

   property p_set_bits;
      @(posedge mclk) disable iff (reset)
         (port.wr && port.op == OP_SET && !soft_reset)
            |=> ((value & $past(port.wdata)) == $past(port.wdata))
            && ((value & ~$past(port.wdata)) == ($past(value) & ~$past(port.wdata)));
   endproperty
   a_set_bits: assert property (p_set_bits) else $error("set alias wrong"); // RULE_09

   property p_clear_bits;
      @(posedge mclk) disable iff (reset)
         (port.wr && port.op == OP_CLEAR && !soft_reset)
            |=> ((value & $past(port.wdata)) == '0)
            && ((value & ~$past(port.wdata)) == ($past(value) & ~$past(port.wdata)));
   endproperty
   a_clear_bits: assert property (p_clear_bits) else $error("clear alias wrong"); // RULE_08

   property p_toggle_bits;
      @(posedge mclk) disable iff (reset)
         (port.wr && port.op == OP_TOGGLE && !soft_reset)
            |=> value == ($past(value) ^ $past(port.wdata));
   endproperty
   a_toggle_bits: assert property (p_toggle_bits) else $error("toggle alias wrong"); // RULE_10

   property p_idle_hold;
      @(posedge mclk) disable iff (reset)
         (!port.wr && !soft_reset) |=> $stable(value);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("base changed without write"); // RULE_12
endmodule

// ===== test/test_reg_bank.sv
/*
 self-checking bench for the register bank: access kinds, reserved bits, resets, aliases.
 assumes reg_conv_pkg and the design files are compiled first; the bench drives all ports.
*/
`timescale 1ns/10ps
module test_reg_bank;
   import reg_conv_pkg::*;
   logic                 mclk       = 1'b0;
   logic                 reset      = 1'b1;
   logic                 soft_reset = 1'b0;
   logic                 wr_en      = 1'b0;
   logic                 rd_en      = 1'b0;
   logic    [ADDR_W-1:0] addr       = '0;
   logic    [DATA_W-1:0] wdata      = '0;
   logic    [5:0]        hw_status  = '0;
   logic    [DATA_W-1:0] rdata;
   logic                 rvalid;
   logic    [3:0]        ctrl_out;
   logic    [DATA_W-1:0] port_out;
   logic                 cmd_pulse;
   logic    [DATA_W-1:0] cmd_data;
   logic                 debug_out;
   int                   bad_count       = 0;
   int                   samples_checked = 0;
   int                   cycles          = 0;

   reg_bank dut_u (.mclk(mclk), .reset(reset), .soft_reset(soft_reset), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .hw_status(hw_status), .rdata(rdata),
      .rvalid(rvalid), .ctrl_out(ctrl_out), .port_out(port_out), .cmd_pulse(cmd_pulse),
      .cmd_data(cmd_data), .debug_out(debug_out));

   always #2 mclk = ~mclk;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hang guard, whole run needs under a hundred cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // write request held one cycle; the next access replaces the strobes
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wr_en = 1'b1;
      rd_en = 1'b0;
      addr  = a;
      wdata = d;
      @(negedge mclk);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
      rd_en = 1'b1;
      wr_en = 1'b0;
      addr  = a;
      @(negedge mclk);
      rd_en = 1'b0;
      check({7'h00, rvalid}, 8'h01, "rvalid");
      check(rdata, exp, what);
      @(negedge mclk);
      check({7'h00, rvalid}, 8'h00, "rvalid drop");
   endtask

   task automatic t_after_reset();
      rdchk(ADDR_CTRL, CTRL_RST, "ctrl reset");
      rdchk(ADDR_OUT, OUT_RST, "out reset");
      rdchk(ADDR_DEBUG, DEBUG_RST, "debug reset");
      check({port_out}, 8'h00, "port_out reset");
      $display("test after_reset done");
   endtask

   task automatic t_access_kinds();
      wr(ADDR_CTRL, 8'h0F);
      wr(ADDR_DEBUG, 8'h01);
      wr(ADDR_STATUS, 8'h3F);
      wr(ADDR_CMD, 8'h5A);
      check({7'h00, cmd_pulse}, 8'h01, "cmd pulse");
      wr(4'h9, 8'h00);
      check({7'h00, cmd_pulse}, 8'h00, "cmd pulse ends");
      rdchk(ADDR_CTRL, 8'h0F, "ctrl rw");
      check({4'h0, ctrl_out}, 8'h0F, "ctrl_out");
      rdchk(ADDR_DEBUG, 8'h01, "debug reserved");
      rdchk(ADDR_STATUS, {2'b00, hw_status}, "status ro");
      check(cmd_data, 8'h5A, "cmd stored");
      rdchk(4'h9, 8'h00, "unmapped");
      wr(ADDR_CTRL, 8'h03);
      rdchk(ADDR_CTRL, 8'h03, "ctrl rewrite");
      $display("test access_kinds done");
   endtask

   task automatic t_alias();
      wr(ADDR_OUT, 8'hA5);
      wr(ADDR_OUTSET, 8'h0A);
      rdchk(ADDR_OUT, 8'hAF, "set");
      wr(ADDR_OUTCLR, 8'h81);
      wr(ADDR_OUTTGL, 8'hF0);
      rdchk(ADDR_OUT, 8'hDE, "clear then toggle");
      rdchk(ADDR_OUTCLR, 8'hDE, "clear alias read");
      rdchk(ADDR_OUTSET, 8'hDE, "set alias read");
      rdchk(ADDR_OUTTGL, 8'hDE, "toggle alias read");
      check(port_out, 8'hDE, "port_out");
      wr(ADDR_OUTTGL, 8'h00);
      wr(ADDR_OUTSET, 8'h00);
      wr(ADDR_OUTCLR, 8'h00);
      rdchk(ADDR_OUT, 8'hDE, "zero mask");
      wr(ADDR_OUTTGL, 8'hFF);
      rdchk(ADDR_OUT, 8'h21, "toggle all");
      $display("test alias done");
   endtask

   task automatic t_soft_reset();
      wr(ADDR_CTRL, 8'h05);
      wr(ADDR_OUT, 8'h33);
      wr(ADDR_DEBUG, 8'h01);
      wr_en      = 1'b0;
      soft_reset = 1'b1;
      @(negedge mclk);
      soft_reset = 1'b0;
      rdchk(ADDR_CTRL, CTRL_RST, "soft ctrl");
      rdchk(ADDR_OUT, OUT_RST, "soft out");
      rdchk(ADDR_DEBUG, 8'h01, "soft keeps debug");
      check({7'h00, debug_out}, 8'h01, "debug_out kept");
      check(cmd_data, CMD_RST, "soft cmd");
      wr(ADDR_OUT, 8'h44);
      // soft reset beats a same-cycle out write, not a debug write
      soft_reset = 1'b1;
      wr(ADDR_OUT, 8'h77);
      wr(ADDR_DEBUG, 8'h00);
      soft_reset = 1'b0;
      rdchk(ADDR_OUT, OUT_RST, "soft beats write");
      rdchk(ADDR_DEBUG, 8'h00, "debug write in soft");
      wr(ADDR_DEBUG, 8'h01);
      wr(ADDR_CMD, 8'h5A);
      wr_en = 1'b0;
      reset = 1'b1;
      @(negedge mclk);
      reset = 1'b0;
      rdchk(ADDR_DEBUG, DEBUG_RST, "power reset debug");
      check(cmd_data, CMD_RST, "power reset cmd");
      check({7'h00, debug_out}, 8'h00, "power reset debug_out");
      $display("test soft_reset done");
   endtask

   initial begin
      hw_status = 6'h2A;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      t_after_reset();
      t_access_kinds();
      t_alias();
      t_soft_reset();
      summarize();
   end
endmodule
